// ===== design/swpm_top.sv
// per-port power management states, d3hot filtering, pme retry and turn-off fence
//
// Contract
// (RL1) a downstream port's power state affects only that port and its link
// (RL2) a port in d3hot requests l1 on its link regardless of other ports
// (RL3) upstream port state governs the switch; low power after acks arrive
// (RL4) fundamental reset puts every port into d0 uninitialized
// (RL5) d0 uninitialized moves to d0 active once bridge is configured
// (RL6) d0 active enters d3hot when d3hot encoding written to state field
// (RL7) d3hot returns to d0 uninitialized on d0 write; power removal gives d3cold
// (RL8) d3hot to d0 resets nothing; context kept flag reads as preserved
// (RL9) in d3hot type 0 configuration requests are accepted and completed
// (RL10) in d3hot messages targeting the bridge are accepted
// (RL11) in d3hot other primary side requests are unsupported requests
// (RL12) in d3hot errors from received tlps are reported as in d0
// (RL13) in d3hot errors from other causes are discarded
// (RL14) in d3hot completions targeting the bridge are unexpected completions
// (RL15) in d3hot passing completions are routed as in d0
// (RL16) in d3hot secondary side requests are unsupported requests
// (RL17) no pme messages are generated while in d3cold
// (RL18) downstream ports send hot-plug pme from d3hot, port or whole switch
// (RL19) after pme send, timer runs; if event still pending on expiry, resend
// (RL20) root puts all devices in d3 then broadcasts turn-off
// (RL21) entering d3 moves links to l1; turn-off is answered with an ack
// (RL22) turn-off broadcast downstream; ack upstream after all active acks
// (RL23) downstream ack timeout acts as ack and moves link to l2/l3 ready
// (RL24) state field 00 is d0, 11 is d3hot; other encodings are ignored
`default_nettype none

module swpm_top #(
	parameter int NUM_PORTS = 4,
	parameter int ADDR_W    = 8
) (
	input  wire logic                          aclk,
	input  wire logic                          aresetn,
	input  wire logic [ADDR_W-1:0]             s_axi_awaddr,
	input  wire logic                          s_axi_awvalid,
	output logic                               s_axi_awready,
	input  wire logic [31:0]                   s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output logic                               s_axi_wready,
	output logic [1:0]                         s_axi_bresp,
	output logic                               s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	input  wire logic [ADDR_W-1:0]             s_axi_araddr,
	input  wire logic                          s_axi_arvalid,
	output logic                               s_axi_arready,
	output logic [31:0]                        s_axi_rdata,
	output logic [1:0]                         s_axi_rresp,
	output logic                               s_axi_rvalid,
	input  wire logic                          s_axi_rready,
	input  wire logic                          power_removed,
	input  wire logic [NUM_PORTS-1:0]          rx_valid,
	input  wire logic [NUM_PORTS-1:0]          rx_secondary,
	input  wire logic [NUM_PORTS-1:0][2:0]     rx_kind,
	output logic      [NUM_PORTS-1:0]          rx_disp_valid,
	output logic      [NUM_PORTS-1:0][1:0]     rx_disp,
	input  wire logic [NUM_PORTS-1:0]          err_tlp,
	input  wire logic [NUM_PORTS-1:0]          err_other,
	output logic      [NUM_PORTS-1:0]          err_msg,
	input  wire logic [NUM_PORTS-1:0]          hp_event,
	output logic      [NUM_PORTS-1:0]          pme_send,
	output logic      [NUM_PORTS-1:0]          l1_req,
	input  wire logic [NUM_PORTS-1:0]          link_active,
	input  wire logic                          turnoff_rx,
	input  wire logic                          up_tlp_rx,
	output logic      [NUM_PORTS-1:0]          turnoff_tx,
	input  wire logic [NUM_PORTS-1:0]          ack_rx,
	output logic                               to_ack_tx,
	output logic      [NUM_PORTS-1:0]          l23_ready,
	output logic                               switch_low_power
);

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] base,
		input int p);
		return a == ADDR_W'(base) + ADDR_W'(4 * p);
	endfunction

	function automatic logic [1:0] ps_code(input swpm_pkg::swpm_state_e s);
		return (s == swpm_pkg::D3_HOT || s == swpm_pkg::D3_COLD) ?
			swpm_pkg::PS_D3HOT : swpm_pkg::PS_D0;
	endfunction

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] strb);
		return {strb[1] ? d[15:8] : old[15:8], strb[0] ? d[7:0] : old[7:0]};
	endfunction

	function automatic swpm_pkg::swpm_disp_e classify(input logic [2:0] kind,
		input logic sec, input logic d3);
		if (kind == swpm_pkg::TK_CPL_PASS)
			return swpm_pkg::DP_ROUTE; // RL15
		if (!d3)
			return (kind == swpm_pkg::TK_REQ_OTHER) ? swpm_pkg::DP_ROUTE : swpm_pkg::DP_ACCEPT;
		if (kind == swpm_pkg::TK_CPL_SELF)
			return swpm_pkg::DP_UC; // RL14
		if (sec)
			return swpm_pkg::DP_UR; // RL16
		if (kind == swpm_pkg::TK_CFG0 || kind == swpm_pkg::TK_MSG_SELF)
			return swpm_pkg::DP_ACCEPT; // RL9 RL10
		return swpm_pkg::DP_UR; // RL11
	endfunction

	swpm_pkg::swpm_state_e           st [NUM_PORTS];
	swpm_pkg::swpm_to_e              to_st;
	logic [NUM_PORTS-1:0]            pend;
	logic [NUM_PORTS-1:0]            ack_pend;
	logic [NUM_PORTS-1:0]            l23_dn;
	logic                            l23_up;
	logic [NUM_PORTS-1:0][15:0]      retry_to;
	logic [NUM_PORTS-1:0][15:0]      toack_to;
	logic [ADDR_W-1:0]               aw_addr;
	logic                            aw_full;
	logic [31:0]                     w_data;
	logic [3:0]                      w_strb;
	logic                            w_full;
	logic                            wr_fire;
	logic                            wr_ok;
	logic [31:0]                     rd_data;
	logic                            rd_ok;
	logic [$clog2(swpm_pkg::TICK_CYCLES)-1:0] tick_cnt;
	logic                            tick;
	logic                            to_start;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// register bus: write address and data taken independently
	assign s_axi_awready = !aw_full;
	assign s_axi_wready  = !w_full;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_fire       = aw_full && w_full && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full <= 1'b0;
			aw_addr <= '0;
		end else if (s_axi_awvalid && !aw_full) begin
			aw_full <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_full <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_full <= 1'b0;
			w_data <= '0;
			w_strb <= '0;
		end else if (s_axi_wvalid && !w_full) begin
			w_full <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_full <= 1'b0;
		end
	end

	always_comb begin
		wr_ok = (aw_addr == ADDR_W'(swpm_pkg::CFG_OFFS)) ||
			(aw_addr == ADDR_W'(swpm_pkg::STAT_OFFS));
		for (int p = 0; p < NUM_PORTS; p++) begin
			if (hit(aw_addr, swpm_pkg::CTL_BASE, p) || hit(aw_addr, swpm_pkg::RETRY_BASE, p) ||
				hit(aw_addr, swpm_pkg::TOACK_BASE, p))
				wr_ok = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= swpm_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_ok ? swpm_pkg::RESP_OKAY : swpm_pkg::RESP_DECERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_comb begin
		rd_data = '0;
		rd_ok   = 1'b0;
		for (int p = 0; p < NUM_PORTS; p++) begin
			if (hit(s_axi_araddr, swpm_pkg::CTL_BASE, p)) begin
				rd_ok = 1'b1;
				rd_data[swpm_pkg::PS_LSB +: 2] = ps_code(st[p]);
				rd_data[swpm_pkg::CTX_BIT]     = 1'b1; // RL8
				rd_data[swpm_pkg::PEND_BIT]    = pend[p];
			end
			if (hit(s_axi_araddr, swpm_pkg::RETRY_BASE, p)) begin
				rd_ok         = 1'b1;
				rd_data[15:0] = retry_to[p];
			end
			if (hit(s_axi_araddr, swpm_pkg::TOACK_BASE, p)) begin
				rd_ok         = 1'b1;
				rd_data[15:0] = toack_to[p];
			end
			if (s_axi_araddr == ADDR_W'(swpm_pkg::STAT_OFFS))
				rd_data[2*p +: 2] = st[p];
		end
		if (s_axi_araddr == ADDR_W'(swpm_pkg::STAT_OFFS)) begin
			rd_ok                       = 1'b1;
			rd_data[swpm_pkg::LOWP_BIT] = switch_low_power;
			rd_data[swpm_pkg::BUSY_BIT] = (to_st == swpm_pkg::TO_WAIT);
		end
		if (s_axi_araddr == ADDR_W'(swpm_pkg::CFG_OFFS))
			rd_ok = 1'b1;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= swpm_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_data;
			s_axi_rresp  <= rd_ok ? swpm_pkg::RESP_OKAY : swpm_pkg::RESP_DECERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// shared timebase so both timeout fields count in ticks
	assign tick = (tick_cnt == '0);

	always_ff @(posedge aclk) begin
		if (!aresetn || tick)
			tick_cnt <= $bits(tick_cnt)'(swpm_pkg::TICK_CYCLES - 1);
		else
			tick_cnt <= tick_cnt - 1'b1;
	end

	// turn-off fence, owned by the upstream port
	assign to_start = (to_st == swpm_pkg::TO_IDLE) && turnoff_rx;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			to_st     <= swpm_pkg::TO_IDLE;
			to_ack_tx <= 1'b0;
			l23_up    <= 1'b0;
		end else begin
			to_ack_tx <= 1'b0;
			case (to_st)
				swpm_pkg::TO_IDLE: begin
					if (turnoff_rx)
						to_st <= swpm_pkg::TO_WAIT;
				end
				swpm_pkg::TO_WAIT: begin
					// a tlp before our ack abandons aggregation only upstream
					if (up_tlp_rx) begin
						to_st <= swpm_pkg::TO_IDLE;
					end else if (ack_pend == '0) begin
						to_ack_tx <= 1'b1; // RL21 RL22
						l23_up    <= 1'b1;
						to_st     <= swpm_pkg::TO_DONE;
					end
				end
				swpm_pkg::TO_DONE: ;
				default: to_st <= swpm_pkg::TO_IDLE;
			endcase
		end
	end

	assign l23_ready = l23_dn | {{(NUM_PORTS-1){1'b0}}, l23_up};

	always_ff @(posedge aclk) begin
		if (!aresetn)
			switch_low_power <= 1'b0;
		else
			switch_low_power <= (st[swpm_pkg::UP_PORT] == swpm_pkg::D3_HOT) &&
				(to_st == swpm_pkg::TO_DONE); // RL3
	end

	for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
		localparam bit IS_DOWN = (p != swpm_pkg::UP_PORT);
		logic        wr_ctl;
		logic        wr_ps;
		logic        wr_cfg;
		logic        d3;
		logic        pme_ok;
		logic        armed;
		logic [15:0] pme_cnt;
		logic [15:0] ack_cnt;

		assign wr_ctl   = wr_fire && hit(aw_addr, swpm_pkg::CTL_BASE, p);
		assign wr_ps    = wr_ctl && w_strb[0];
		assign wr_cfg   = wr_fire && (aw_addr == ADDR_W'(swpm_pkg::CFG_OFFS)) &&
			w_strb[p / 8] && w_data[p];
		assign d3       = (st[p] == swpm_pkg::D3_HOT); // RL1
		// pme allowed from own or whole-switch d3hot, never from d3cold
		assign pme_ok   = IS_DOWN && (d3 || st[swpm_pkg::UP_PORT] == swpm_pkg::D3_HOT) &&
			st[p] != swpm_pkg::D3_COLD &&
			st[swpm_pkg::UP_PORT] != swpm_pkg::D3_COLD; // RL17 RL18

		// leaving d3hot only changes state, no register is reinitialised
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				st[p] <= swpm_pkg::D0_UNINIT; // RL4
			end else begin
				case (st[p])
					swpm_pkg::D0_UNINIT: begin
						if (wr_cfg)
							st[p] <= swpm_pkg::D0_ACTIVE; // RL5
					end
					swpm_pkg::D0_ACTIVE: begin
						if (wr_ps && w_data[swpm_pkg::PS_LSB +: 2] == swpm_pkg::PS_D3HOT)
							st[p] <= swpm_pkg::D3_HOT; // RL6 RL24
					end
					swpm_pkg::D3_HOT: begin
						if (power_removed)
							st[p] <= swpm_pkg::D3_COLD; // RL7
						else if (wr_ps && w_data[swpm_pkg::PS_LSB +: 2] == swpm_pkg::PS_D0)
							st[p] <= swpm_pkg::D0_UNINIT; // RL7 RL8 RL24
					end
					swpm_pkg::D3_COLD: ;
					default: st[p] <= swpm_pkg::D0_UNINIT;
				endcase
			end
		end

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				retry_to[p] <= swpm_pkg::RETRY_RST;
				toack_to[p] <= swpm_pkg::TOACK_RST;
			end else if (wr_fire) begin
				if (hit(aw_addr, swpm_pkg::RETRY_BASE, p))
					retry_to[p] <= merge16(retry_to[p], w_data, w_strb);
				if (hit(aw_addr, swpm_pkg::TOACK_BASE, p))
					toack_to[p] <= merge16(toack_to[p], w_data, w_strb);
			end
		end

		// new event beats a simultaneous write-one-to-clear
		always_ff @(posedge aclk) begin
			if (!aresetn)
				pend[p] <= 1'b0;
			else if (hp_event[p] && IS_DOWN)
				pend[p] <= 1'b1;
			else if (wr_ctl && w_strb[1] && w_data[swpm_pkg::PEND_BIT])
				pend[p] <= 1'b0;
		end

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				armed       <= 1'b0;
				pme_cnt     <= '0;
				pme_send[p] <= 1'b0;
			end else begin
				pme_send[p] <= 1'b0;
				if (!armed) begin
					if (pend[p] && pme_ok) begin
						pme_send[p] <= 1'b1; // RL18
						armed       <= 1'b1;
						pme_cnt     <= retry_to[p];
					end
				end else if (tick) begin
					if (pme_cnt <= 16'h0001) begin
						if (pend[p] && pme_ok) begin
							pme_send[p] <= 1'b1; // RL19
							pme_cnt     <= retry_to[p];
						end else begin
							armed <= 1'b0;
						end
					end else begin
						pme_cnt <= pme_cnt - 16'h0001;
					end
				end
			end
		end

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				l1_req[p]        <= 1'b0;
				err_msg[p]       <= 1'b0;
				rx_disp_valid[p] <= 1'b0;
				rx_disp[p]       <= swpm_pkg::DP_ACCEPT;
			end else begin
				l1_req[p]        <= d3; // RL2 RL21
				err_msg[p]       <= err_tlp[p] || (err_other[p] && !d3); // RL12 RL13
				rx_disp_valid[p] <= rx_valid[p];
				rx_disp[p]       <= classify(rx_kind[p], rx_secondary[p], d3);
			end
		end

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				ack_pend[p]   <= 1'b0;
				ack_cnt       <= '0;
				l23_dn[p]     <= 1'b0;
				turnoff_tx[p] <= 1'b0;
			end else begin
				turnoff_tx[p] <= to_start && link_active[p] && IS_DOWN; // RL22
				if (to_start && link_active[p] && IS_DOWN) begin
					ack_pend[p] <= 1'b1;
					ack_cnt     <= toack_to[p];
				end else if (ack_pend[p]) begin
					if (ack_rx[p]) begin
						ack_pend[p] <= 1'b0;
						l23_dn[p]   <= 1'b1;
					end else if (tick) begin
						if (ack_cnt <= 16'h0001) begin
							ack_pend[p] <= 1'b0; // RL23
							l23_dn[p]   <= 1'b1;
						end else begin
							ack_cnt <= ack_cnt - 16'h0001;
						end
					end
				end
			end
		end

		reset_uninit_a: assert property (@(posedge aclk) disable iff (1'b0) // RL4
			!aresetn |=> st[p] == swpm_pkg::D0_UNINIT)
			else $error("port not in d0 uninitialized after reset");
		cfg_active_a: assert property (st[p] == swpm_pkg::D0_UNINIT && wr_cfg // RL5
			|=> st[p] == swpm_pkg::D0_ACTIVE)
			else $error("configured bridge did not reach d0 active");
		d3_entry_a: assert property (st[p] == swpm_pkg::D0_ACTIVE && wr_ps && // RL6
			w_data[1:0] == swpm_pkg::PS_D3HOT |=> st[p] == swpm_pkg::D3_HOT)
			else $error("d3hot write did not enter d3hot");
		d3_exit_a: assert property (d3 && !power_removed && wr_ps && // RL7
			w_data[1:0] == swpm_pkg::PS_D0 && !w_data[swpm_pkg::PEND_BIT] && !hp_event[p]
			|=> st[p] == swpm_pkg::D0_UNINIT && pend[p] == $past(pend[p]))
			else $error("d0 write from d3hot misbehaved");
		bad_ps_a: assert property (wr_ps && (w_data[1:0] == 2'h1 || w_data[1:0] == 2'h2) && // RL24
			!power_removed && !wr_cfg |=> $stable(st[p]))
			else $error("unsupported encoding changed state");
		l1_follow_a: assert property ($rose(d3) |=> l1_req[p] ##1 l1_req[p] || !d3) // RL2
			else $error("d3hot port did not request l1");
		disp_ur_a: assert property (rx_valid[p] && d3 && rx_kind[p] == swpm_pkg::TK_REQ_OTHER // RL11
			|=> rx_disp_valid[p] && rx_disp[p] == swpm_pkg::DP_UR)
			else $error("d3hot request not unsupported");
		err_drop_a: assert property (err_other[p] && !err_tlp[p] && d3 |=> !err_msg[p]) // RL13
			else $error("non-tlp error escaped in d3hot");
		pme_cold_a: assert property (st[swpm_pkg::UP_PORT] == swpm_pkg::D3_COLD // RL17
			|=> !pme_send[p])
			else $error("pme sent while in d3cold");
	end

	toack_after_a: assert property ($rose(to_ack_tx) |-> ack_pend == '0 && // RL22
		$past(to_st) == swpm_pkg::TO_WAIT)
		else $error("ack sent before downstream acks");

	d3_seen_c: cover property (st[swpm_pkg::UP_PORT] == swpm_pkg::D3_HOT);
	pme_resend_c: cover property (pme_send[1] ##[1:1000] pme_send[1]);
	to_ack_c: cover property (to_ack_tx);
	abandon_c: cover property (to_st == swpm_pkg::TO_WAIT && up_tlp_rx);

endmodule

`default_nettype wire

// ===== design/swpm_pkg.sv
// constants and types for the switch port power management block
`default_nettype none

package swpm_pkg;

	// clock and timer tick
	localparam int CLK_PERIOD_NS = 5;
	localparam int TICK_NS       = 1000;
	localparam int TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// register byte offsets, one word per port from each base
	localparam logic [7:0] CTL_BASE   = 8'h00;
	localparam logic [7:0] RETRY_BASE = 8'h10;
	localparam logic [7:0] TOACK_BASE = 8'h20;
	localparam logic [7:0] CFG_OFFS   = 8'h30;
	localparam logic [7:0] STAT_OFFS  = 8'h34;

	// pm_control_status_reg fields, then the status register bits LOWP_BIT and BUSY_BIT
	localparam int PS_LSB   = 0;
	localparam int CTX_BIT  = 3;
	localparam int PEND_BIT = 15;
	localparam int LOWP_BIT = 31;
	localparam int BUSY_BIT = 30;

	// power_state_field encodings
	localparam logic [1:0] PS_D0    = 2'h0;
	localparam logic [1:0] PS_D3HOT = 2'h3;

	// reset values of the timeout fields, in ticks
	localparam logic [15:0] RETRY_RST = 16'h0064;
	localparam logic [15:0] TOACK_RST = 16'h0064;

	localparam int UP_PORT = 0;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef enum logic [1:0] {D0_UNINIT, D0_ACTIVE, D3_HOT, D3_COLD} swpm_state_e;
	typedef enum logic [2:0] {TK_CFG0, TK_MSG_SELF, TK_CPL_SELF, TK_CPL_PASS,
		TK_REQ_OTHER} swpm_kind_e;
	typedef enum logic [1:0] {DP_ACCEPT, DP_ROUTE, DP_UR, DP_UC} swpm_disp_e;
	typedef enum logic [1:0] {TO_IDLE, TO_WAIT, TO_DONE} swpm_to_e;

endpackage

`default_nettype wire

// ===== tb/swpm_link_partner.sv
// far-side model: downstream devices answering turn-off broadcasts
`default_nettype none

module swpm_link_partner #(
	parameter int NUM_PORTS = 4,
	parameter int ACK_DLY   = 12
) (
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire logic [NUM_PORTS-1:0] ack_en,
	input  wire logic [NUM_PORTS-1:0] turnoff_tx,
	output logic      [NUM_PORTS-1:0] ack_rx
);
	timeunit 1ns;
	timeprecision 1ps;

	int cnt [NUM_PORTS];

	// a silent port leaves the bridge to its own ack timeout
	always @(posedge aclk) begin
		for (int p = 0; p < NUM_PORTS; p++) begin
			if (!aresetn) begin
				cnt[p] <= 0;
				ack_rx[p] <= 1'b0;
			end else if (turnoff_tx[p] && ack_en[p]) begin
				cnt[p] <= ACK_DLY;
				ack_rx[p] <= 1'b0;
			end else begin
				ack_rx[p] <= (cnt[p] == 1);
				if (cnt[p] > 0)
					cnt[p] <= cnt[p] - 1;
			end
		end
	end
endmodule

`default_nettype wire

// ===== tb/swpm_top_test.sv
// self-checking bench for the switch port power management block
`default_nettype none

module swpm_top_test;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int NP    = 4;
	localparam int LIMIT = 20000;
	localparam logic [1:0] UN = swpm_pkg::D0_UNINIT, AC = swpm_pkg::D0_ACTIVE;
	localparam logic [1:0] HT = swpm_pkg::D3_HOT, CD = swpm_pkg::D3_COLD;
	localparam logic [1:0] DA = swpm_pkg::DP_ACCEPT, DR = swpm_pkg::DP_ROUTE;
	localparam logic [1:0] DU = swpm_pkg::DP_UR, DC = swpm_pkg::DP_UC;
	localparam logic [7:0] ST = swpm_pkg::STAT_OFFS;

	logic aclk = 1'b0, aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, power_removed = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [NP-1:0] rx_valid = '0, rx_secondary = '0, err_tlp = '0, err_other = '0;
	logic [NP-1:0] hp_event = '0, link_active = '0, ack_en = '0, ack_rx;
	logic [NP-1:0][2:0] rx_kind = '0;
	logic [NP-1:0][1:0] rx_disp;
	logic [NP-1:0] rx_disp_valid, err_msg, pme_send, l1_req, turnoff_tx, l23_ready;
	logic turnoff_rx = 1'b0, up_tlp_rx = 1'b0, to_ack_tx, switch_low_power;
	int n_mismatch = 0, checked = 0, cyc = 0, ack_cnt = 0, n, c;
	int pme_cnt [NP] = '{default: 0};
	int toff_cnt [NP] = '{default: 0};
	logic [31:0] rdv;
	logic [1:0] tab [3][5] = '{'{DA, DA, DC, DR, DU}, '{DU, DU, DC, DR, DU},
		'{DA, DA, DA, DR, DR}};

	swpm_top u_swpm_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .power_removed, .rx_valid, .rx_secondary,
		.rx_kind, .rx_disp_valid, .rx_disp, .err_tlp, .err_other, .err_msg, .hp_event,
		.pme_send, .l1_req, .link_active, .turnoff_rx, .up_tlp_rx, .turnoff_tx, .ack_rx,
		.to_ack_tx, .l23_ready, .switch_low_power);

	swpm_link_partner u_swpm_link_partner (.aclk, .aresetn, .ack_en, .turnoff_tx, .ack_rx);

	always #2.5 aclk = ~aclk;

	// pulse monitors read pre-edge values, so no race with the design
	always @(posedge aclk) begin
		cyc++;
		ack_cnt += int'(to_ack_tx === 1'b1);
		for (int p = 0; p < NP; p++) begin
			pme_cnt[p] += int'(pme_send[p] === 1'b1);
			toff_cnt[p] += int'(turnoff_tx[p] === 1'b1);
		end
		if (cyc == LIMIT) begin
			n_mismatch++;
			conclude();
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// ready is sampled mid-cycle; it cannot move before the next edge
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_hit, w_hit, b_hit;
		logic [1:0] resp;
		b_hit = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		// only the bench timeout ends a wait for the answer
		while (!b_hit) begin
			@(negedge aclk);
			aw_hit = s_axi_awvalid && (s_axi_awready === 1'b1);
			w_hit = s_axi_wvalid && (s_axi_wready === 1'b1);
			b_hit = (s_axi_bvalid === 1'b1);
			resp = s_axi_bresp;
			@(posedge aclk);
			if (aw_hit) s_axi_awvalid <= 1'b0;
			if (w_hit) s_axi_wvalid <= 1'b0;
			if (b_hit) s_axi_bready <= 1'b0;
		end
		chk({30'h0, resp}, {30'h0, er}, "write response");
	endtask

	task rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
		logic ar_hit, r_hit;
		r_hit = 1'b0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!r_hit) begin
			@(negedge aclk);
			ar_hit = s_axi_arvalid && (s_axi_arready === 1'b1);
			r_hit = (s_axi_rvalid === 1'b1);
			rdv = s_axi_rdata;
			@(posedge aclk);
			if (ar_hit) s_axi_arvalid <= 1'b0;
			if (r_hit) s_axi_rready <= 1'b0;
		end
		chk(rdv & m, exp, "read data");
	endtask

	task ps(input int p, input logic [31:0] v);
		wr(swpm_pkg::CTL_BASE + 8'(4 * p), v, swpm_pkg::RESP_OKAY);
	endtask

	task tlp(input int p, input logic sec, input int k, input logic [1:0] e);
		@(posedge aclk);
		rx_valid[p] <= 1'b1;
		rx_secondary[p] <= sec;
		rx_kind[p] <= 3'(k);
		@(posedge aclk);
		rx_valid[p] <= 1'b0;
		@(negedge aclk);
		chk({31'h0, rx_disp_valid[p]}, 32'h1, "disposition valid");
		chk({30'h0, rx_disp[p]}, {30'h0, e}, "disposition");
	endtask

	task err(input int p, input logic from_tlp, input logic e);
		@(posedge aclk);
		err_tlp[p] <= from_tlp;
		err_other[p] <= !from_tlp;
		@(posedge aclk);
		err_tlp[p] <= 1'b0;
		err_other[p] <= 1'b0;
		@(negedge aclk);
		chk({31'h0, err_msg[p]}, {31'h0, e}, "error message");
	endtask

	task hp_pulse(input int p);
		@(posedge aclk);
		hp_event[p] <= 1'b1;
		@(posedge aclk);
		hp_event[p] <= 1'b0;
	endtask

	task sc_reset;
		rchk(ST, 32'hff, 32'h0);
		rchk(swpm_pkg::CTL_BASE + 8'h4, 32'hf, 32'h8);
		rchk(swpm_pkg::RETRY_BASE + 8'h4, 32'hffff, 32'(swpm_pkg::RETRY_RST));
		rchk(swpm_pkg::TOACK_BASE + 8'h8, 32'hffff, 32'(swpm_pkg::TOACK_RST));
		wr(8'h40, 32'h1, swpm_pkg::RESP_DECERR);
		chk({28'h0, l1_req}, 32'h0, "no l1 after reset");
	endtask

	task sc_states;
		wr(swpm_pkg::CFG_OFFS, 32'h6, swpm_pkg::RESP_OKAY);
		rchk(ST, 32'hff, {24'h0, UN, AC, AC, UN});
		ps(1, {30'h0, swpm_pkg::PS_D3HOT});
		ps(2, 32'h1);
		rchk(ST, 32'hff, {24'h0, UN, AC, HT, UN});
		chk({28'h0, l1_req}, 32'h2, "l1 request");
		rchk(swpm_pkg::CTL_BASE + 8'h4, 32'hf, 32'hb);
	endtask

	task sc_filter;
		for (int k = 0; k < 5; k++) begin
			tlp(1, 1'b0, k, tab[0][k]);
			tlp(1, 1'b1, k, tab[1][k]);
			tlp(2, 1'b0, k, tab[2][k]);
		end
		err(1, 1'b1, 1'b1);
		err(1, 1'b0, 1'b0);
		err(2, 1'b0, 1'b1);
	endtask

	task sc_pme;
		// two ticks: the resend lands 201..400 cycles out whatever the tick phase
		wr(swpm_pkg::RETRY_BASE + 8'h4, 32'h2, swpm_pkg::RESP_OKAY);
		c = pme_cnt[1];
		hp_pulse(1);
		repeat (20) @(posedge aclk);
		chk(32'(pme_cnt[1] - c), 32'h1, "first event message");
		repeat (100) @(posedge aclk);
		chk(32'(pme_cnt[1] - c), 32'h1, "early resend");
		n = 0;
		while (pme_cnt[1] - c < 2 && n < 500) begin
			@(posedge aclk);
			n++;
		end
		chk(32'(pme_cnt[1] - c), 32'h2, "resend on expiry");
		ps(1, 32'h8003);
		c = pme_cnt[1];
		repeat (600) @(posedge aclk);
		chk(32'(pme_cnt[1] - c), 32'h0, "resend after clear");
	endtask

	task sc_wake;
		ps(1, {30'h0, swpm_pkg::PS_D0});
		rchk(ST, 32'hff, {24'h0, UN, AC, UN, UN});
		rchk(swpm_pkg::RETRY_BASE + 8'h4, 32'hffff, 32'h2);
		chk({28'h0, l1_req}, 32'h0, "l1 after wake");
	endtask

	task sc_fence;
		wr(swpm_pkg::CFG_OFFS, 32'h3, swpm_pkg::RESP_OKAY);
		// two ticks keep the timeout clear of the early checks
		wr(swpm_pkg::TOACK_BASE + 8'h8, 32'h2, swpm_pkg::RESP_OKAY);
		for (int p = 0; p < 3; p++) ps(p, 32'h3);
		link_active <= 4'h6;
		ack_en <= 4'h2;
		c = ack_cnt;
		@(posedge aclk);
		turnoff_rx <= 1'b1;
		@(posedge aclk);
		turnoff_rx <= 1'b0;
		repeat (60) @(posedge aclk);
		for (int p = 0; p < NP; p++) chk(32'(toff_cnt[p]), {31'h0, p == 1 || p == 2}, "bcast");
		chk(32'(ack_cnt - c), 32'h0, "ack before all ports");
		chk({31'h0, l23_ready[1]}, 32'h1, "acked port l23");
		n = 0;
		while (ack_cnt == c && n < 600) begin
			@(posedge aclk);
			n++;
		end
		chk(32'(ack_cnt - c), 32'h1, "ack upstream");
		repeat (3) @(posedge aclk);
		chk({28'h0, l23_ready}, 32'h7, "l23 ready");
		chk({31'h0, switch_low_power}, 32'h1, "switch low power");
		chk({28'h0, l1_req}, 32'h7, "l1 in d3");
	endtask

	task sc_cold;
		@(posedge aclk);
		power_removed <= 1'b1;
		rchk(ST, 32'hff, {24'h0, UN, CD, CD, CD});
		c = pme_cnt[1];
		hp_pulse(1);
		repeat (600) @(posedge aclk);
		chk(32'(pme_cnt[1] - c), 32'h0, "event in d3cold");
		@(posedge aclk);
		aresetn <= 1'b0;
		power_removed <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rchk(ST, 32'hff, 32'h0);
	endtask

	task conclude;
		$display("checked %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		sc_reset();
		sc_states();
		sc_filter();
		sc_pme();
		sc_wake();
		sc_fence();
		sc_cold();
		conclude();
	end
endmodule

`default_nettype wire
